/* File: logic/csu_cmp_if.sv */
// carrier between the sequencer and the comparator
`timescale 1ns/10ps
interface csu_cmp_if;
    logic [7:0] file_byte;
    logic [7:0] accum;
    csu_pkg::csu_kind_t kind;
    logic start;
    logic hit;
    modport seq (output file_byte, output accum, output kind, output start, input hit);
    modport unit (input file_byte, input accum, input kind, input start, output hit);
endinterface

/* File: logic/csu_compare.sv */
// unsigned subtract comparator with registered verdict
`timescale 1ns/10ps
`include "csu_consts.svh"
module csu_compare (
    input wire logic clk_in,
    input wire logic rstn_in,
    csu_cmp_if.unit cmp
);
    csu_pkg::csu_cmp_t s_r;
    csu_pkg::csu_cmp_t s_nxt;
    logic [8:0] diff;
    logic borrow;
    logic zero;

    // accumulator taken from file byte, borrow means file byte is below
    assign diff = {1'b0, cmp.file_byte} - {1'b0, cmp.accum};
    assign borrow = diff[8];
    assign zero = (diff[7:0] == 8'h00);

    always_comb begin
        s_nxt = s_r;
        if (cmp.start) begin
            unique case (cmp.kind)
                csu_pkg::CSU_K_EQ: s_nxt.hit = zero;
                csu_pkg::CSU_K_GT: s_nxt.hit = !borrow && !zero;
                csu_pkg::CSU_K_LT: s_nxt.hit = borrow;
                default: s_nxt.hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmp.hit = s_r.hit;
endmodule // csu_compare

/* File: logic/csu_consts.svh */
// constants for the compare-and-skip unit
`ifndef CSU_CONSTS_SVH
`define CSU_CONSTS_SVH
`define CSU_OP_HI 4'h6
`define CSU_SUB_LT 3'h0
`define CSU_SUB_EQ 3'h1
`define CSU_SUB_GT 3'h2
`define CSU_OP_HI_MSB 15
`define CSU_OP_HI_LSB 12
`define CSU_SUB_MSB 11
`define CSU_SUB_LSB 9
`define CSU_BANK_FLAG_BIT 8
`define CSU_FADDR_MSB 7
`define CSU_ACCESS_SPLIT 8'h80
`define CSU_ACCESS_LO_BANK 4'h0
`define CSU_ACCESS_HI_BANK 4'hF
`define CSU_Q1 2'h0
`define CSU_Q2 2'h1
`define CSU_Q3 2'h2
`define CSU_Q4 2'h3
`define CSU_SKIP_NONE 2'h0
`define CSU_SKIP_ONE 2'h1
`define CSU_SKIP_TWO 2'h2
`endif

/* File: logic/csu_pkg.sv */
// types for the compare-and-skip unit
package csu_pkg;
    typedef enum logic [1:0] {
        CSU_K_LT,
        CSU_K_EQ,
        CSU_K_GT
    } csu_kind_t;

    typedef enum logic [1:0] {
        CSU_S_IDLE,
        CSU_S_EXEC,
        CSU_S_SKIP1,
        CSU_S_SKIP2
    } csu_state_t;

    typedef struct packed {
        csu_state_t st;
        logic [1:0] ph;
        logic [15:0] word;
        csu_kind_t kind;
        logic [11:0] addr;
        logic rd;
        logic [7:0] fbyte;
        logic [7:0] acc;
        logic start;
        logic two_word;
        logic discard;
        logic nop;
        logic done;
        logic [1:0] skip_words;
        logic active;
    } csu_seq_t;

    typedef struct packed {
        logic hit;
    } csu_cmp_t;
endpackage

/* File: logic/csu_top.sv */
// compare-and-skip instruction sequencer
`timescale 1ns/10ps
`include "csu_consts.svh"
module csu_top (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic next_two_word_in,
    input wire logic [7:0] working_accumulator_in,
    input wire logic [3:0] bank_pointer_register_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [11:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic flags_we_out,
    output logic [1:0] phase_out,
    output logic active_out,
    output logic nop_cycle_out,
    output logic discard_out,
    output logic done_out,
    output logic [1:0] skip_words_out
);
    csu_pkg::csu_seq_t s_r;
    csu_pkg::csu_seq_t s_nxt;
    csu_cmp_if cmp_bus ();

    logic [2:0] op_sub;
    logic is_compare;
    logic bank_flag;
    logic [7:0] faddr;
    logic [3:0] bank;

    assign op_sub = s_r.word[`CSU_SUB_MSB:`CSU_SUB_LSB];
    assign bank_flag = s_r.word[`CSU_BANK_FLAG_BIT];
    assign faddr = s_r.word[`CSU_FADDR_MSB:0];

    // only the three compare encodings belong here; others are left to the core
    assign is_compare = (instr_word_in[`CSU_OP_HI_MSB:`CSU_OP_HI_LSB] == `CSU_OP_HI)
        && ((instr_word_in[`CSU_SUB_MSB:`CSU_SUB_LSB] == `CSU_SUB_LT)
        || (instr_word_in[`CSU_SUB_MSB:`CSU_SUB_LSB] == `CSU_SUB_EQ)
        || (instr_word_in[`CSU_SUB_MSB:`CSU_SUB_LSB] == `CSU_SUB_GT));

    // access bank splits low addresses to the bottom bank, high ones to the top
    always_comb begin
        if (bank_flag) begin
            bank = bank_pointer_register_in;
        end else if (faddr < `CSU_ACCESS_SPLIT) begin
            bank = `CSU_ACCESS_LO_BANK;
        end else begin
            bank = `CSU_ACCESS_HI_BANK;
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.discard = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.rd = 1'b0;
        unique case (s_r.st)
            csu_pkg::CSU_S_IDLE: begin
                s_nxt.active = 1'b0;
                s_nxt.nop = 1'b0;
                if (instr_valid_in && is_compare) begin
                    s_nxt.word = instr_word_in;
                    s_nxt.st = csu_pkg::CSU_S_EXEC;
                    s_nxt.ph = `CSU_Q1;
                    s_nxt.active = 1'b1;
                end
            end
            csu_pkg::CSU_S_EXEC: begin
                s_nxt.ph = s_r.ph + 2'h1;
                unique case (s_r.ph)
                    `CSU_Q1: begin
                        // decode, and present the address for the read phase
                        unique case (op_sub)
                            `CSU_SUB_EQ: s_nxt.kind = csu_pkg::CSU_K_EQ;
                            `CSU_SUB_GT: s_nxt.kind = csu_pkg::CSU_K_GT;
                            default: s_nxt.kind = csu_pkg::CSU_K_LT;
                        endcase
                        s_nxt.addr = {bank, faddr};
                        s_nxt.rd = 1'b1;
                    end
                    `CSU_Q2: begin
                        // read of register f; data arrive one cycle after the strobe
                        s_nxt.acc = working_accumulator_in;
                    end
                    `CSU_Q3: begin
                        s_nxt.fbyte = mem_rdata_in;
                        s_nxt.start = 1'b1;
                    end
                    default: begin
                        // fourth phase writes nothing; verdict is ready here
                        if (cmp_bus.hit) begin
                            s_nxt.discard = 1'b1;
                            s_nxt.two_word = next_two_word_in;
                            s_nxt.st = csu_pkg::CSU_S_SKIP1;
                            s_nxt.nop = 1'b1;
                        end else begin
                            s_nxt.st = csu_pkg::CSU_S_IDLE;
                            s_nxt.done = 1'b1;
                            s_nxt.skip_words = `CSU_SKIP_NONE;
                            s_nxt.active = 1'b0;
                        end
                    end
                endcase
            end
            csu_pkg::CSU_S_SKIP1: begin
                // whole cycle is a no-op; nothing is read or written
                s_nxt.ph = s_r.ph + 2'h1;
                if (s_r.ph == `CSU_Q4) begin
                    if (s_r.two_word) begin
                        s_nxt.st = csu_pkg::CSU_S_SKIP2;
                    end else begin
                        s_nxt.st = csu_pkg::CSU_S_IDLE;
                        s_nxt.done = 1'b1;
                        s_nxt.nop = 1'b0;
                        s_nxt.active = 1'b0;
                        s_nxt.skip_words = `CSU_SKIP_ONE;
                    end
                end
            end
            csu_pkg::CSU_S_SKIP2: begin
                s_nxt.ph = s_r.ph + 2'h1;
                if (s_r.ph == `CSU_Q4) begin
                    s_nxt.st = csu_pkg::CSU_S_IDLE;
                    s_nxt.done = 1'b1;
                    s_nxt.nop = 1'b0;
                    s_nxt.active = 1'b0;
                    s_nxt.skip_words = `CSU_SKIP_TWO;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // comparator is fed the next-state file byte and start so its registered verdict is ready in the fourth phase
    assign cmp_bus.file_byte = s_nxt.fbyte;
    assign cmp_bus.accum = s_r.acc;
    assign cmp_bus.kind = s_r.kind;
    assign cmp_bus.start = s_nxt.start;

    csu_compare u_cmp (
        .clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .cmp(cmp_bus.unit)
    );

    // write and flag strobes held low by a flop; compares never store
    logic quiet_r;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            quiet_r <= 1'b0;
        end else begin
            quiet_r <= 1'b0;
        end
    end

    assign mem_addr_out = s_r.addr;
    assign mem_rd_out = s_r.rd;
    assign mem_wr_out = quiet_r;
    assign flags_we_out = quiet_r;
    assign phase_out = s_r.ph;
    assign active_out = s_r.active;
    assign nop_cycle_out = s_r.nop;
    assign discard_out = s_r.discard;
    assign done_out = s_r.done;
    assign skip_words_out = s_r.skip_words;
endmodule // csu_top

/* File: verif/csu_mem_model.sv */
// banked data memory stand-in for the sequencer
`timescale 1ns/10ps
module csu_mem_model (
    input wire logic clk_in,
    input wire logic [11:0] addr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:4095];
    initial begin
        rdata_out = 8'h00;
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'hA5 ^ i[7:0];
    end
    // outside the read slot the bus toggles, so stale data never passes as valid
    always @(posedge clk_in)
        rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
endmodule // csu_mem_model

/* File: verif/csu_top_checker.sv */
// assertions on the compare-and-skip sequencer ports
`timescale 1ns/10ps
module csu_top_checker (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic [3:0] bank_pointer_register_in,
    input wire logic [11:0] mem_addr_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic flags_we_out,
    input wire logic [1:0] phase_out,
    input wire logic active_out,
    input wire logic nop_cycle_out,
    input wire logic discard_out,
    input wire logic done_out,
    input wire logic [1:0] skip_words_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic tk = instr_valid_in && !active_out && instr_word_in[15:12] == 4'h6
        && instr_word_in[11:9] < 3'h3;
    property p_take;
        tk |=> active_out && phase_out == 2'h0 ##1 mem_rd_out && phase_out == 2'h1;
    endproperty
    property p_addr;
        logic [15:0] w;
        logic [3:0] b;
        (tk, w = instr_word_in) ##1 (1, b = bank_pointer_register_in)
            |-> ##1 mem_addr_out == (w[8] ? {b, w[7:0]} : {{4{w[7]}}, w[7:0]});
    endproperty
    property p_five;
        tk |-> ##5 (done_out || discard_out);
    endproperty
    property p_rd;
        mem_rd_out |-> phase_out == 2'h1 ##1 !mem_rd_out && phase_out == 2'h2;
    endproperty
    property p_quiet;
        !mem_wr_out && !flags_we_out;
    endproperty
    property p_skip1;
        discard_out |-> nop_cycle_out
            ##4 ((done_out && skip_words_out == 2'h1) || (nop_cycle_out && phase_out == 2'h0));
    endproperty
    property p_skip2;
        nop_cycle_out && phase_out == 2'h0 && !discard_out
            |-> ##4 done_out && skip_words_out == 2'h2;
    endproperty
    property p_nop;
        nop_cycle_out |-> !mem_rd_out && !done_out;
    endproperty
    property p_done;
        done_out |-> !active_out && !nop_cycle_out ##1 !done_out;
    endproperty
    a_take: assert property (p_take) else $error("bad start");
    a_addr: assert property (p_addr) else $error("bad address");
    a_five: assert property (p_five) else $error("late verdict");
    a_rd: assert property (p_rd) else $error("bad read slot");
    a_quiet: assert property (p_quiet) else $error("write seen");
    a_skip1: assert property (p_skip1) else $error("bad skip");
    a_skip2: assert property (p_skip2) else $error("bad long skip");
    a_nop: assert property (p_nop) else $error("nop not quiet");
    a_done: assert property (p_done) else $error("bad done");
    c_plain: cover property (tk ##5 done_out);
    c_skip: cover property (discard_out);
    c_long: cover property (done_out && skip_words_out == 2'h2);
endmodule // csu_top_checker
bind csu_top csu_top_checker u_chk (.core_clk_in, .rstn_in, .instr_valid_in, .instr_word_in,
    .bank_pointer_register_in, .mem_addr_out, .mem_rd_out, .mem_wr_out, .flags_we_out,
    .phase_out, .active_out, .nop_cycle_out, .discard_out, .done_out, .skip_words_out);

/* File: verif/csu_top_tb.sv */
// self-checking bench for the compare-and-skip sequencer
`timescale 1ns/10ps
module csu_top_tb;
    logic clk, rstn, iv, two, rd, wr, fl, act, nop, disc, done;
    logic [15:0] iw;
    logic [7:0] acc, rdata;
    logic [3:0] bank;
    logic [11:0] addr;
    logic [1:0] ph, sw;
    int error_cnt = 0;
    int n_checks = 0;
    // word, accumulator, bank, file byte, two-word next, expected skip words
    logic [38:0] rows [7] = '{
        {16'h6210, 8'h5A, 4'h3, 8'h5A, 1'b0, 2'h1},
        {16'h6310, 8'h5A, 4'h3, 8'h5B, 1'b0, 2'h0},
        {16'h6490, 8'h7F, 4'h2, 8'h80, 1'b1, 2'h2},
        {16'h6520, 8'h33, 4'hA, 8'h33, 1'b0, 2'h0},
        {16'h6040, 8'h80, 4'h1, 8'h7F, 1'b0, 2'h1},
        {16'h61FF, 8'h00, 4'h5, 8'hFF, 1'b1, 2'h0},
        {16'h6005, 8'h01, 4'h6, 8'h00, 1'b1, 2'h2}};
    csu_top u_dut (.core_clk_in(clk), .rstn_in(rstn), .instr_valid_in(iv), .instr_word_in(iw),
        .next_two_word_in(two), .working_accumulator_in(acc), .bank_pointer_register_in(bank),
        .mem_rdata_in(rdata), .mem_addr_out(addr), .mem_rd_out(rd), .mem_wr_out(wr),
        .flags_we_out(fl), .phase_out(ph), .active_out(act), .nop_cycle_out(nop),
        .discard_out(disc), .done_out(done), .skip_words_out(sw));
    csu_mem_model u_mem (.clk_in(clk), .addr_in(addr), .rd_in(rd), .rdata_out(rdata));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // access bank splits at 0x80 between bank 0 and the top bank
    function automatic logic [11:0] ea(input logic [15:0] w, input logic [3:0] b);
        return w[8] ? {b, w[7:0]} : {{4{w[7]}}, w[7:0]};
    endfunction
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #50000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        logic [7:0] f;
        logic [1:0] s;
        int n, nd;
        {rstn, iv, two, iw, acc, bank} = '0;
        repeat (20) @(posedge clk);
        check("reset outs", {act, rd, wr, fl, nop, disc, done, sw, ph}, 0);
        #2 rstn = 1'b1;
        for (int i = 0; i < 7; i++) begin
            {iw, acc, bank, f, two, s} = rows[i];
            u_mem.mem[ea(iw, bank)] = f;
            iv = 1'b1;
            @(posedge clk);
            #2 iv = 1'b0;
            n = 0;
            nd = 0;
            while (done !== 1'b1 && n < 20) begin
                @(posedge clk);
                #2 n++;
                nd += (disc === 1'b1);
            end
            check("skip_words", sw, s);
            check("cycles", n, 4 + 4 * s);
            check("discards", nd, s != 0);
            check("mem_addr", addr, ea(iw, bank));
            $display("row %0d done", i);
        end
        iw = 16'h6600;
        iv = 1'b1;
        repeat (6) begin
            @(posedge clk);
            #2 check("ignored", act, 0);
        end
        $display("ignore test done");
        iw = 16'h6210;
        repeat (3) @(posedge clk);
        #2 rstn = 1'b0;
        #1 check("reset mid", {act, rd, nop, disc, done, ph}, 0);
        iv = 1'b0;
        $display("reset test done");
        report_and_stop();
    end
endmodule // csu_top_tb
